//--- core/mhw_pkg.sv
package mhw_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_SRCA   = 8'h04;
    localparam logic [7:0] OFF_SRCB   = 8'h08;
    localparam logic [7:0] OFF_ACC    = 8'h0c;
    localparam logic [7:0] OFF_FXEXC  = 8'h10;
    localparam logic [7:0] OFF_CFZERO = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_INTST  = 8'h1c;
    localparam logic [7:0] OFF_INTMSK = 8'h20;

    // Control field positions
    localparam int CTRL_SIGNED = 0;
    localparam int CTRL_SAT    = 1;
    localparam int CTRL_RECORD = 2;
    localparam int CTRL_OVFEN  = 3;
    localparam int CTRL_START  = 4;

    // Exception word: summary at bit 31, overflow at bit 30
    localparam int FX_SUMMARY = 31;
    localparam int FX_OVERFLOW = 30;

    // Interrupt status bits
    localparam int INT_DONE = 0;
    localparam int INT_OVF  = 1;

    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [31:0] SAT_SPOS  = 32'h7fff_ffff;
    localparam logic [31:0] SAT_SNEG  = 32'h8000_0000;
    localparam logic [31:0] SAT_UMAX  = 32'hffff_ffff;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_MUL  = 3'h2,
        ST_ACC  = 3'h4
    } mhw_state_t;

    typedef struct packed {
        logic overflowEn;
        logic recordEn;
        logic saturate;
        logic isSigned;
    } mhw_ctrl_t;

    // Condition field: lt, gt, eq, summary copy
    typedef struct packed {
        logic lt;
        logic gt;
        logic eq;
        logic so;
    } mhw_cond_t;

endpackage

//--- core/mhw_mac.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// - Operands are upper halfwords of both sources
// - Form 32-bit product, signed or unsigned
// - Add product to accumulator, 33-bit sum
// - Modulo forms keep the low 32 bits
// - Saturating forms clamp on overflow
// - Saturating signed without overflow stores low word
// - Unsigned forms accumulate the unsigned product
// - Plain form leaves flags and condition untouched
// - Record form updates condition field only
// - Overflow form updates overflow and summary only
// - Combined form updates both from result
module mhw_mac (
    input  wire logic        clk,           // Core clock
    input  wire logic        sys_rst,       // Synchronous reset, high
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    output logic             irq            // Level interrupt
);

    logic [7:0]          awAddr_r;
    logic                awHeld_r;
    logic [31:0]         wData_r;
    logic [3:0]          wStrb_r;
    logic                wHeld_r;
    logic [31:0]         wrMask;
    logic                awTake;
    logic                wTake;
    logic                wrCommit;
    logic                arTake;
    logic                wrHit;
    logic                rdHit;
    logic [31:0]         rdWord;

    mhw_pkg::mhw_state_t state_r;
    mhw_pkg::mhw_state_t state_nxt;
    mhw_pkg::mhw_ctrl_t  ctrl_r;
    mhw_pkg::mhw_cond_t  condFieldZero_r;
    mhw_pkg::mhw_cond_t  condNew;
    logic [31:0]         srcRegA_r;
    logic [31:0]         srcRegB_r;
    logic [31:0]         acc_r;
    logic [31:0]         product_r;
    logic [31:0]         fixedPointExceptionReg_r;
    logic [1:0]          intStat_r;
    logic [1:0]          intMask_r;
    logic [1:0]          intEvent;
    logic [1:0]          intStat_nxt;

    logic                busy;
    logic                startReq;
    logic                wrCtrl;
    logic                wrSrcA;
    logic                wrSrcB;
    logic                wrAcc;
    logic                wrFx;
    logic                wrIntSt;
    logic                wrIntMsk;
    logic signed [31:0]  prodSigned;
    logic [31:0]         prodUnsigned;
    logic [32:0]         sum33;
    logic                overflowFlag;
    logic [31:0]         result;
    logic                soBase;
    logic                soNew;

    assign awTake   = s_axi_awvalid && s_axi_awready;
    assign wTake    = s_axi_wvalid && s_axi_wready;
    assign wrCommit = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign arTake   = s_axi_arvalid && s_axi_arready;
    assign busy     = (state_r != mhw_pkg::ST_IDLE);

    // Byte lane mask from the held strobes
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wrMask[8*gi +: 8] = {8{wStrb_r[gi]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // Write decode; operand and control writes are dropped while a pass runs
    // so software cannot change the accumulator underneath the datapath.
    always_comb begin
        wrHit    = 1'b1;
        wrCtrl   = 1'b0;
        wrSrcA   = 1'b0;
        wrSrcB   = 1'b0;
        wrAcc    = 1'b0;
        wrFx     = 1'b0;
        wrIntSt  = 1'b0;
        wrIntMsk = 1'b0;
        case (awAddr_r)
            mhw_pkg::OFF_CTRL:   wrCtrl   = wrCommit && !busy;
            mhw_pkg::OFF_SRCA:   wrSrcA   = wrCommit && !busy;
            mhw_pkg::OFF_SRCB:   wrSrcB   = wrCommit && !busy;
            mhw_pkg::OFF_ACC:    wrAcc    = wrCommit && !busy;
            mhw_pkg::OFF_FXEXC:  wrFx     = wrCommit;
            mhw_pkg::OFF_CFZERO: wrHit    = 1'b1;
            mhw_pkg::OFF_STATUS: wrHit    = 1'b1;
            mhw_pkg::OFF_INTST:  wrIntSt  = wrCommit;
            mhw_pkg::OFF_INTMSK: wrIntMsk = wrCommit;
            default:             wrHit    = 1'b0;
        endcase
    end

    assign startReq = wrCtrl && wStrb_r[0] && wData_r[mhw_pkg::CTRL_START];

    // Write address and data channels, taken in either order
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awHeld_r      <= 1'b0;
            awAddr_r      <= 8'h00;
            s_axi_awready <= 1'b1;
        end else begin
            if (awTake) begin
                awAddr_r <= s_axi_awaddr;
            end
            awHeld_r      <= (awHeld_r || awTake) && !wrCommit;
            s_axi_awready <= !((awHeld_r || awTake) && !wrCommit);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wHeld_r      <= 1'b0;
            wData_r      <= mhw_pkg::RST_WORD;
            wStrb_r      <= 4'h0;
            s_axi_wready <= 1'b1;
        end else begin
            if (wTake) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            wHeld_r      <= (wHeld_r || wTake) && !wrCommit;
            s_axi_wready <= !((wHeld_r || wTake) && !wrCommit);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= mhw_pkg::RESP_OKAY;
        end else if (wrCommit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? mhw_pkg::RESP_OKAY : mhw_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux; reads have no side effects
    always_comb begin
        rdHit  = 1'b1;
        rdWord = mhw_pkg::RST_WORD;
        case (s_axi_araddr)
            mhw_pkg::OFF_CTRL:   rdWord = {28'h0000000, ctrl_r};
            mhw_pkg::OFF_SRCA:   rdWord = srcRegA_r;
            mhw_pkg::OFF_SRCB:   rdWord = srcRegB_r;
            mhw_pkg::OFF_ACC:    rdWord = acc_r;
            mhw_pkg::OFF_FXEXC:  rdWord = fixedPointExceptionReg_r;
            mhw_pkg::OFF_CFZERO: rdWord = {28'h0000000, condFieldZero_r};
            mhw_pkg::OFF_STATUS: rdWord = {31'h00000000, busy};
            mhw_pkg::OFF_INTST:  rdWord = {30'h00000000, intStat_r};
            mhw_pkg::OFF_INTMSK: rdWord = {30'h00000000, intMask_r};
            default:             rdHit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= mhw_pkg::RST_WORD;
            s_axi_rresp   <= mhw_pkg::RESP_OKAY;
        end else if (arTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdWord;
            s_axi_rresp   <= rdHit ? mhw_pkg::RESP_OKAY : mhw_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Sequencer: multiply in one cycle, accumulate and write back in the next
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mhw_pkg::ST_IDLE: state_nxt = startReq ? mhw_pkg::ST_MUL : mhw_pkg::ST_IDLE;
            mhw_pkg::ST_MUL:  state_nxt = mhw_pkg::ST_ACC;
            mhw_pkg::ST_ACC:  state_nxt = mhw_pkg::ST_IDLE;
            default:          state_nxt = mhw_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= mhw_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Big-endian bits 0..15 are the upper halfword here
    assign prodSigned   = $signed(srcRegA_r[31:16]) * $signed(srcRegB_r[31:16]);
    assign prodUnsigned = srcRegA_r[31:16] * srcRegB_r[31:16];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            product_r <= mhw_pkg::RST_WORD;
        end else if (state_r == mhw_pkg::ST_MUL) begin
            product_r <= ctrl_r.isSigned ? prodSigned : prodUnsigned;
        end
    end

    // One adder serves both kinds; only the extension of the operands differs
    always_comb begin
        if (ctrl_r.isSigned) begin
            sum33        = {acc_r[31], acc_r} + {product_r[31], product_r};
            overflowFlag = sum33[32] != sum33[31];
        end else begin
            sum33        = {1'b0, acc_r} + {1'b0, product_r};
            overflowFlag = sum33[32];
        end
        if (ctrl_r.saturate && overflowFlag) begin
            if (!ctrl_r.isSigned) begin
                result = mhw_pkg::SAT_UMAX;
            end else if (sum33[32]) begin
                result = mhw_pkg::SAT_SNEG;
            end else begin
                result = mhw_pkg::SAT_SPOS;
            end
        end else begin
            result = sum33[31:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_r <= mhw_pkg::RST_WORD;
        end else if (state_r == mhw_pkg::ST_ACC) begin
            acc_r <= result;
        end else if (wrAcc) begin
            acc_r <= merge(acc_r, wData_r, wrMask);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            srcRegA_r <= mhw_pkg::RST_WORD;
            srcRegB_r <= mhw_pkg::RST_WORD;
        end else begin
            if (wrSrcA) begin
                srcRegA_r <= merge(srcRegA_r, wData_r, wrMask);
            end
            if (wrSrcB) begin
                srcRegB_r <= merge(srcRegB_r, wData_r, wrMask);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= '0;
        end else if (wrCtrl && wStrb_r[0]) begin
            ctrl_r <= wData_r[mhw_pkg::CTRL_OVFEN:mhw_pkg::CTRL_SIGNED];
        end
    end

    // Exception word: a hardware set of summary beats a software clear
    assign soBase = wrFx && wStrb_r[3] ? wData_r[mhw_pkg::FX_SUMMARY]
                                       : fixedPointExceptionReg_r[mhw_pkg::FX_SUMMARY];
    assign soNew  = soBase || overflowFlag;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fixedPointExceptionReg_r <= mhw_pkg::RST_WORD;
        end else begin
            if (wrFx && wStrb_r[3]) begin
                fixedPointExceptionReg_r[mhw_pkg::FX_SUMMARY]  <= wData_r[mhw_pkg::FX_SUMMARY];
                fixedPointExceptionReg_r[mhw_pkg::FX_OVERFLOW] <= wData_r[mhw_pkg::FX_OVERFLOW];
            end
            if (state_r == mhw_pkg::ST_ACC && ctrl_r.overflowEn) begin
                fixedPointExceptionReg_r[mhw_pkg::FX_OVERFLOW] <= overflowFlag;
                fixedPointExceptionReg_r[mhw_pkg::FX_SUMMARY]  <= soNew;
            end
        end
    end

    // Condition compares the written word as signed, summary taken after update
    always_comb begin
        condNew.lt = result[31];
        condNew.gt = !result[31] && (result != mhw_pkg::RST_WORD);
        condNew.eq = (result == mhw_pkg::RST_WORD);
        condNew.so = ctrl_r.overflowEn ? soNew : soBase;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            condFieldZero_r <= '0;
        end else if (state_r == mhw_pkg::ST_ACC && ctrl_r.recordEn) begin
            condFieldZero_r <= condNew;
        end
    end
    // Without record or overflow enable neither block above fires.

    // Interrupt status: set wins over a write-one clear
    assign intEvent[mhw_pkg::INT_DONE] = (state_r == mhw_pkg::ST_ACC);
    assign intEvent[mhw_pkg::INT_OVF]  = (state_r == mhw_pkg::ST_ACC) && overflowFlag;
    assign intStat_nxt = (intStat_r & ~(wrIntSt && wStrb_r[0] ? wData_r[1:0] : 2'h0)) | intEvent;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            intStat_r <= 2'h0;
            intMask_r <= 2'h0;
            irq       <= 1'b0;
        end else begin
            intStat_r <= intStat_nxt;
            if (wrIntMsk && wStrb_r[0]) begin
                intMask_r <= wData_r[1:0];
            end
            irq <= |(intStat_nxt & (wrIntMsk && wStrb_r[0] ? wData_r[1:0] : intMask_r));
        end
    end

endmodule

//--- verification/mhw_mac_asserts.sv
`timescale 1ns/10ps
module mhw_mac_asserts (
    input wire logic        clk,           // Core clock
    input wire logic        sys_rst,       // Reset
    input wire logic        s_axi_awready, // Aw ready
    input wire logic        s_axi_wready,  // W ready
    input wire logic        s_axi_bvalid,  // B valid
    input wire logic        s_axi_bready,  // B ready
    input wire logic [7:0]  s_axi_araddr,  // Ar address
    input wire logic        s_axi_arvalid, // Ar valid
    input wire logic        s_axi_arready, // Ar ready
    input wire logic [31:0] s_axi_rdata,   // R data
    input wire logic [1:0]  s_axi_rresp,   // R response
    input wire logic        s_axi_rvalid,  // R valid
    input wire logic        s_axi_rready,  // R ready
    input wire logic        irq            // Interrupt
);
    logic [7:0] rdAddr_r;
    logic       arTake;
    assign arTake = s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Remember which register the pending answer belongs to
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdAddr_r <= 8'h00;
        end else if (arTake) begin
            rdAddr_r <= s_axi_araddr;
        end
    end
    rst_idle_a: assert property ($fell(sys_rst) |-> s_axi_awready && s_axi_wready && s_axi_arready && !irq)
        else $error("bus not idle after reset");
    rd_answer_a: assert property (arTake |=> s_axi_rvalid)
        else $error("read answer late");
    rd_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer not retired");
    wr_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not retired");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer waits");
    rd_unmapped_a: assert property (arTake && s_axi_araddr > mhw_pkg::OFF_INTMSK
        |=> s_axi_rresp == mhw_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    fx_fields_a: assert property (s_axi_rvalid && rdAddr_r == mhw_pkg::OFF_FXEXC |-> s_axi_rdata[29:0] == 30'h0)
        else $error("exception word spare bits set");
    cf_fields_a: assert property (s_axi_rvalid && rdAddr_r == mhw_pkg::OFF_CFZERO
        |-> s_axi_rdata[31:4] == 28'h0 && $onehot0(s_axi_rdata[3:1]))
        else $error("condition field malformed");
    ctrl_start_a: assert property (s_axi_rvalid && rdAddr_r == mhw_pkg::OFF_CTRL |-> s_axi_rdata[31:4] == 28'h0)
        else $error("control reads start bit");
endmodule
bind mhw_mac mhw_mac_asserts u_chk (.clk, .sys_rst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

//--- verification/mhw_mac_test.sv
`timescale 1ns/10ps
module mhw_mac_test;
    logic        clk = 1'b0, sysRst = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic        arValid = 1'b0, rReady = 1'b0, awRdy, wRdy, bValid, arRdy, rValid, irq;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0, rData, lastRd, ta[3], tb[3], td[3];
    logic [1:0]  bResp, rResp, fx = 2'h0;
    logic [3:0]  cf = 4'h0;
    logic [34:0] rq[$], e;
    logic [1:0]  bq[$];
    int          failures = 0, tests_run = 0, cyc = 0, seed = 24;
    always #20 clk = ~clk;
    mhw_mac u_dut (.clk(clk), .sys_rst(sysRst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
        .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arRdy), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .irq(irq));
    task automatic chk(input logic [33:0] g, input logic [33:0] x);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw = 1, w = 1;
        bq.push_back(er);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && awRdy === 1'b1) begin
                awValid <= 1'b0;
                aw = 0;
            end
            if (w && wRdy === 1'b1) begin
                wValid <= 1'b0;
                w = 0;
            end
        end
        // Ready goes up only after both channels are taken, so back-to-back calls never touch it twice at one edge
        bReady <= 1'b1;
        do @(posedge clk); while (bValid !== 1'b1);
        bReady <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er, input logic care);
        rq.push_back({care, er, x});
        arAddr <= a;
        arValid <= 1'b1;
        do @(posedge clk); while (arRdy !== 1'b1);
        arValid <= 1'b0;
        rReady <= 1'b1;
        do @(posedge clk); while (rValid !== 1'b1);
        lastRd = rData;
        rReady <= 1'b0;
    endtask
    task automatic waitIdle;
        repeat (4) @(posedge clk);
        do rd(mhw_pkg::OFF_STATUS, 32'h0, 2'h0, 1'b0); while (lastRd[0] !== 1'b0);
    endtask
    // Result comparison runs apart from the drivers so stalls never hide a late answer
    always @(posedge clk) begin
        if (rValid === 1'b1 && rReady === 1'b1) begin
            e = rq.pop_front();
            if (e[34]) chk({rResp, rData}, e[33:0]);
        end
        if (bValid === 1'b1 && bReady === 1'b1) chk({32'h0, bResp}, {32'h0, bq.pop_front()});
        cyc++;
        if (cyc == 40000) begin
            failures++;
            stop_test();
        end
    end
    task automatic runOp(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b, input logic [31:0] d);
        logic [31:0] p, r;
        logic [32:0] s;
        logic        ov;
        if (c[0]) begin
            p = $signed(a[31:16]) * $signed(b[31:16]);
            s = {p[31], p} + {d[31], d};
            ov = s[32] ^ s[31];
        end else begin
            p = a[31:16] * b[31:16];
            s = {1'b0, p} + {1'b0, d};
            ov = s[32];
        end
        r = (c[1] && ov) ? (c[0] ? (s[32] ? mhw_pkg::SAT_SNEG : mhw_pkg::SAT_SPOS) : mhw_pkg::SAT_UMAX) : s[31:0];
        if (c[3]) fx = {fx[1] | ov, ov};
        if (c[2]) cf = {$signed(r) < 0, $signed(r) > 0, r == 32'h0, fx[1]};
        wr(mhw_pkg::OFF_SRCA, a, 2'h0);
        wr(mhw_pkg::OFF_SRCB, b, 2'h0);
        wr(mhw_pkg::OFF_ACC, d, 2'h0);
        wr(mhw_pkg::OFF_CTRL, {27'h0, 1'b1, c}, 2'h0);
        waitIdle();
        rd(mhw_pkg::OFF_ACC, r, 2'h0, 1'b1);
        rd(mhw_pkg::OFF_FXEXC, {fx, 30'h0}, 2'h0, 1'b1);
        rd(mhw_pkg::OFF_CFZERO, {28'h0, cf}, 2'h0, 1'b1);
        rd(mhw_pkg::OFF_INTST, {30'h0, ov, 1'b1}, 2'h0, 1'b1);
        wr(mhw_pkg::OFF_INTST, 32'h3, 2'h0);
    endtask
    initial begin
        ta = '{32'h0, 32'h7fff0000, 32'h80000000};
        tb = '{32'h0, 32'h7fff0000, 32'h7fff0000};
        td = '{32'h0, 32'h7fffffff, 32'h80000000};
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0, 2'h0, 1'b1);
        wr(8'h24, 32'h1, mhw_pkg::RESP_SLVERR);
        rd(8'h24, 32'h0, mhw_pkg::RESP_SLVERR, 1'b1);
        wr(mhw_pkg::OFF_CFZERO, 32'hffffffff, 2'h0);
        rd(mhw_pkg::OFF_CFZERO, 32'h0, 2'h0, 1'b1);
        wr(mhw_pkg::OFF_FXEXC, 32'hffffffff, 2'h0);
        rd(mhw_pkg::OFF_FXEXC, 32'hc0000000, 2'h0, 1'b1);
        wr(mhw_pkg::OFF_FXEXC, 32'h0, 2'h0);
        $display("register map test done");
        // Random operands, and pairs that overflow positive and negative when signed, in every one of the sixteen forms
        for (int k = 0; k < 3; k++) begin
            for (int m = 0; m < 16; m++) begin
                if (k == 0) runOp(4'(m), $random(seed), $random(seed), $random(seed));
                else runOp(4'(m), ta[k], tb[k], td[k]);
            end
        end
        $display("arithmetic test done");
        wr(mhw_pkg::OFF_INTMSK, 32'h1, 2'h0);
        wr(mhw_pkg::OFF_CTRL, 32'h10, 2'h0);
        waitIdle();
        repeat (2) @(posedge clk);
        chk({33'h0, irq}, 34'h1);
        wr(mhw_pkg::OFF_INTMSK, 32'h0, 2'h0);
        repeat (2) @(posedge clk);
        chk({33'h0, irq}, 34'h0);
        wr(mhw_pkg::OFF_INTMSK, 32'h1, 2'h0);
        repeat (2) @(posedge clk);
        chk({33'h0, irq}, 34'h1);
        wr(mhw_pkg::OFF_INTST, 32'h3, 2'h0);
        repeat (2) @(posedge clk);
        chk({33'h0, irq}, 34'h0);
        $display("interrupt test done");
        stop_test();
    end
endmodule
